// ==== src/peak_cancel_stage_defines.svh ====
// register offsets, field widths, reset values for the stage configuration bank
// assumes inclusion by name from the design file and the testbench
`ifndef PEAK_CANCEL_STAGE_DEFINES_SVH
`define PEAK_CANCEL_STAGE_DEFINES_SVH

// printed offsets are register indices; byte address is index times four
`define STAGE1_CANCELER_COUNT_IDX      8'h30
`define STAGE1_DETECT_THRESHOLD_SQ_IDX 8'h31
`define STAGE1_GAIN_THRESHOLD_SQ_IDX   8'h32
`define STAGE1_PULSE_DELAY_IDX         8'h33
`define STAGE2_CANCELER_COUNT_IDX      8'h38
`define STAGE2_DETECT_THRESHOLD_SQ_IDX 8'h39
`define STAGE2_GAIN_THRESHOLD_SQ_IDX   8'h3A
`define STAGE2_PULSE_DELAY_IDX         8'h3B
`define STAGE3_CANCELER_COUNT_IDX      8'h40
`define STAGE3_DETECT_THRESHOLD_SQ_IDX 8'h41
`define STAGE3_GAIN_THRESHOLD_SQ_IDX   8'h42
`define STAGE3_PULSE_DELAY_IDX         8'h43
`define STAGE4_CANCELER_COUNT_IDX      8'h48
// chosen here: stage 4 thresholds/delay, sync selectors, trigger, status
`define STAGE4_DETECT_THRESHOLD_SQ_IDX 8'h49
`define STAGE4_GAIN_THRESHOLD_SQ_IDX   8'h4A
`define STAGE4_PULSE_DELAY_IDX         8'h4B
`define RESOURCE_SYNC_SEL_IDX          8'h1F
`define CANCEL_SYNC_SEL_IDX            8'h1E
`define SOFTWARE_TRIGGER_IDX           8'h1D
`define ACTIVE_STATUS_IDX              8'h1C

`define STAGE_STRIDE     8'h08
`define COUNT_W          4
`define DELAY_W          8
`define THRESH_W         16
`define SEL_W            3
`define COUNT_MAX        4'h8
`define CANCELERS_PER_RAM 3'h4
`define TOTAL_CANCELERS  6'h20
`define REG_RESET        16'h0000
`define TRIG_RESOURCE_BIT 6
`define TRIG_CANCEL_BIT   7
`define AXI_OKAY         2'h0
`define AXI_SLVERR       2'h2

`endif

// ==== src/peak_cancel_stage_pkg.sv ====
// types shared by the stage configuration bank
// assumes the defines header is on the include path
package peak_cancel_stage_pkg;
   typedef enum logic [2:0] {
      sync_never,
      sync_software_trigger,
      sync_timer,
      sync_input_a,
      sync_input_b,
      sync_always
   } sync_source_t;

   typedef enum {
      wr_idle,
      wr_resp
   } write_state_t;
endpackage

// ==== src/peak_cancel_stage_config.sv ====
// configuration register bank for four peak detection and cancellation stages
// assumes an AXI4-Lite master on aclk and sync pulses synchronous to aclk
`timescale 1ns/1ps
`include "peak_cancel_stage_defines.svh"

// Summary of operation
// RULE1: each canceler count holds zero to eight canceler RAMs in bits 3:0; the code stores and applies any value 0 to 15
// RULE2: software keeps the sum of the four counts at eight or less
// RULE3: new counts take effect only on the selected resource sync event
// RULE4: each stage has a 16-bit read/write detection threshold-squared value
// RULE5: each stage has a 16-bit read/write gain threshold-squared value
// RULE6: peaks above detect threshold are cut to gain level if a canceler is free
// RULE7: software derives thresholds from average input power as zero decibels
// RULE8: pulse delay in samples sits in bits 7:0, legal five through 255
// RULE9: software sets delay to half of pulse length minus one, less if min-phase
// RULE10: a written delay reaches the delay element only on cancel sync
// RULE11: all stage registers are 16 bits, reset to zero, reserved bits read zero
// RULE12: 32 cancelers are shared four per canceler RAM count unit
// RULE13: resource sync chosen by 3-bit selector; codes six and seven never fire
// RULE14: shadow copies move to active copies in one cycle on the sync event
module peak_cancel_stage_config
   import peak_cancel_stage_pkg::*;
#(
   parameter int STAGES = 4
) (
   input  wire logic                       aclk,            // core clock
   input  wire logic                       aresetn,         // sync reset, low
   input  wire logic [9:0]                 s_axi_awaddr,    // write byte address
   input  wire logic                       s_axi_awvalid,   // write address valid
   output logic                            s_axi_awready,   // write address ready
   input  wire logic [31:0]                s_axi_wdata,     // write data
   input  wire logic [3:0]                 s_axi_wstrb,     // write byte enables
   input  wire logic                       s_axi_wvalid,    // write data valid
   output logic                            s_axi_wready,    // write data ready
   output logic [1:0]                      s_axi_bresp,     // write response
   output logic                            s_axi_bvalid,    // write response valid
   input  wire logic                       s_axi_bready,    // write response ready
   input  wire logic [9:0]                 s_axi_araddr,    // read byte address
   input  wire logic                       s_axi_arvalid,   // read address valid
   output logic                            s_axi_arready,   // read address ready
   output logic [31:0]                     s_axi_rdata,     // read data
   output logic [1:0]                      s_axi_rresp,     // read response
   output logic                            s_axi_rvalid,    // read data valid
   input  wire logic                       s_axi_rready,    // read data ready
   input  wire logic                       timer_sync,      // timer event pulse
   input  wire logic                       sync_a,          // sync input a pulse
   input  wire logic                       sync_b,          // sync input b pulse
   output logic [STAGES*`COUNT_W-1:0]      active_count,    // applied RAM counts
   output logic [STAGES*6-1:0]             active_cancelers,// cancelers per stage
   output logic [STAGES*`DELAY_W-1:0]      active_delay,    // applied pulse delays
   output logic [STAGES*`THRESH_W-1:0]     detect_thresh_sq,// detection thresholds
   output logic [STAGES*`THRESH_W-1:0]     gain_thresh_sq,  // gain targets
   output logic                            resource_sync_pulse, // counts applied
   output logic                            cancel_sync_pulse    // delays applied
);

   logic [`COUNT_W-1:0]  count_shadow_reg  [STAGES];
   logic [`COUNT_W-1:0]  count_active_reg  [STAGES];
   logic [`DELAY_W-1:0]  delay_shadow_reg  [STAGES];
   logic [`DELAY_W-1:0]  delay_active_reg  [STAGES];
   logic [`THRESH_W-1:0] detect_reg        [STAGES];
   logic [`THRESH_W-1:0] gain_reg          [STAGES];
   logic [`SEL_W-1:0]    resource_sel_reg;
   logic [`SEL_W-1:0]    cancel_sel_reg;
   logic                 sw_resource_reg;
   logic                 sw_cancel_reg;
   logic                 aw_held_reg;
   logic [7:0]           aw_idx_reg;
   logic                 w_held_reg;
   logic [31:0]          w_data_reg;
   logic [3:0]           w_strb_reg;
   write_state_t         wr_state_reg;
   logic [31:0]          rdata_next;
   logic                 rmapped_next;
   logic                 wmapped;
   logic                 wr_fire;
   logic                 resource_event;
   logic                 cancel_event;
   logic [7:0]           ar_idx;

   // sync source decode; unknown codes never fire
   function automatic logic sync_hit(input logic [`SEL_W-1:0] sel, input logic sw);
      logic hit;
      hit = 1'b0;
      case (sel)
         sync_never:            hit = 1'b0;
         sync_software_trigger: hit = sw;
         sync_timer:            hit = timer_sync;
         sync_input_a:          hit = sync_a;
         sync_input_b:          hit = sync_b;
         sync_always:           hit = 1'b1;
         default:               hit = 1'b0;
      endcase
      return hit;
   endfunction

   assign resource_event      = sync_hit(resource_sel_reg, sw_resource_reg); // see RULE13
   assign cancel_event        = sync_hit(cancel_sel_reg, sw_cancel_reg);
   assign resource_sync_pulse = resource_event;
   assign cancel_sync_pulse   = cancel_event;

   // write channel: address and data taken in either order, one at a time
   assign s_axi_awready = !aw_held_reg && (wr_state_reg == wr_idle);
   assign s_axi_wready  = !w_held_reg && (wr_state_reg == wr_idle);
   assign wr_fire       = aw_held_reg && w_held_reg && (wr_state_reg == wr_idle);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         aw_idx_reg  <= 8'h00;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[9:2];
         end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end else if (wr_fire) begin
            w_held_reg <= 1'b0;
         end
      end
   end

   always_comb begin
      wmapped = 1'b0;
      case (aw_idx_reg)
         `RESOURCE_SYNC_SEL_IDX, `CANCEL_SYNC_SEL_IDX,
         `SOFTWARE_TRIGGER_IDX, `ACTIVE_STATUS_IDX: wmapped = 1'b1;
         default: begin
            for (int s = 0; s < STAGES; s++) begin
               if (aw_idx_reg[7:2] == 6'(({2'b0, `STAGE1_CANCELER_COUNT_IDX}
                     + s * `STAGE_STRIDE) >> 2)) begin
                  wmapped = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= wr_idle;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_OKAY;
      end else begin
         case (wr_state_reg)
            wr_idle: begin
               if (wr_fire) begin
                  wr_state_reg <= wr_resp;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wmapped ? `AXI_OKAY : `AXI_SLVERR;
               end
            end
            wr_resp: begin
               if (s_axi_bready) begin
                  wr_state_reg <= wr_idle;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: wr_state_reg <= wr_idle;
         endcase
      end
   end

   // sync selectors and one-cycle software trigger bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         resource_sel_reg <= 3'h0;
         cancel_sel_reg   <= 3'h0;
         sw_resource_reg  <= 1'b0;
         sw_cancel_reg    <= 1'b0;
      end else begin
         sw_resource_reg <= 1'b0;
         sw_cancel_reg   <= 1'b0;
         if (wr_fire && w_strb_reg[0]) begin
            if (aw_idx_reg == `RESOURCE_SYNC_SEL_IDX) begin
               resource_sel_reg <= w_data_reg[`SEL_W-1:0]; // see RULE13
            end
            if (aw_idx_reg == `CANCEL_SYNC_SEL_IDX) begin
               cancel_sel_reg <= w_data_reg[`SEL_W-1:0];
            end
            if (aw_idx_reg == `SOFTWARE_TRIGGER_IDX) begin
               sw_resource_reg <= w_data_reg[`TRIG_RESOURCE_BIT];
               sw_cancel_reg   <= w_data_reg[`TRIG_CANCEL_BIT];
            end
         end
      end
   end

   // per-stage registers, shadow and active copies
   for (genvar g = 0; g < STAGES; g++) begin : stage
      localparam logic [7:0] BASE = 8'(`STAGE1_CANCELER_COUNT_IDX + g * `STAGE_STRIDE);
      localparam logic [7:0] DETECT_IDX = 8'(`STAGE1_DETECT_THRESHOLD_SQ_IDX + g * `STAGE_STRIDE);
      localparam logic [7:0] GAIN_IDX   = 8'(`STAGE1_GAIN_THRESHOLD_SQ_IDX + g * `STAGE_STRIDE);
      localparam logic [7:0] DELAY_IDX  = 8'(`STAGE1_PULSE_DELAY_IDX + g * `STAGE_STRIDE);
      logic                  count_hit;
      logic                  detect_hit;
      logic                  gain_hit;
      logic                  delay_hit;

      // index match only; the strobes qualify the byte lanes below
      assign count_hit  = wr_fire && (aw_idx_reg == BASE);
      assign detect_hit = wr_fire && (aw_idx_reg == DETECT_IDX);
      assign gain_hit   = wr_fire && (aw_idx_reg == GAIN_IDX);
      assign delay_hit  = wr_fire && (aw_idx_reg == DELAY_IDX);

      // reserved upper bits are dropped, not stored
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            count_shadow_reg[g] <= '0; // see RULE11
         end else if (count_hit && w_strb_reg[0]) begin
            count_shadow_reg[g] <= w_data_reg[`COUNT_W-1:0]; // see RULE1
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            delay_shadow_reg[g] <= '0;
         end else if (delay_hit && w_strb_reg[0]) begin
            delay_shadow_reg[g] <= w_data_reg[`DELAY_W-1:0]; // see RULE8
         end
      end

      // thresholds take each byte lane on its own strobe
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            detect_reg[g] <= '0;
         end else if (detect_hit) begin
            if (w_strb_reg[0]) begin
               detect_reg[g][7:0] <= w_data_reg[7:0]; // see RULE4
            end
            if (w_strb_reg[1]) begin
               detect_reg[g][15:8] <= w_data_reg[15:8];
            end
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            gain_reg[g] <= '0;
         end else if (gain_hit) begin
            if (w_strb_reg[0]) begin
               gain_reg[g][7:0] <= w_data_reg[7:0]; // see RULE5
            end
            if (w_strb_reg[1]) begin
               gain_reg[g][15:8] <= w_data_reg[15:8];
            end
         end
      end

      // old allocation and delay stay in force until their own sync event
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            count_active_reg[g] <= '0;
            delay_active_reg[g] <= '0;
         end else begin
            if (resource_event) begin
               count_active_reg[g] <= count_shadow_reg[g]; // see RULE3 see RULE14
            end
            if (cancel_event) begin
               delay_active_reg[g] <= delay_shadow_reg[g]; // see RULE10 see RULE14
            end
         end
      end

      // applied counts, cancelers, delays and thresholds driven out to the stage datapath
      assign active_count[g*`COUNT_W +: `COUNT_W]     = count_active_reg[g]; // see RULE6
      assign active_cancelers[g*6 +: 6] =
         6'(count_active_reg[g]) * 6'(`CANCELERS_PER_RAM); // see RULE12
      assign active_delay[g*`DELAY_W +: `DELAY_W]     = delay_active_reg[g];
      assign detect_thresh_sq[g*`THRESH_W +: `THRESH_W] = detect_reg[g]; // see RULE6
      assign gain_thresh_sq[g*`THRESH_W +: `THRESH_W]   = gain_reg[g];
   end

   // read decode; reserved bits read zero, unmapped answers slverr
   assign ar_idx = s_axi_araddr[9:2];

   always_comb begin
      rdata_next   = 32'h0000_0000;
      rmapped_next = 1'b0;
      case (ar_idx)
         `RESOURCE_SYNC_SEL_IDX: begin
            rdata_next   = {29'h0, resource_sel_reg};
            rmapped_next = 1'b1;
         end
         `CANCEL_SYNC_SEL_IDX: begin
            rdata_next   = {29'h0, cancel_sel_reg};
            rmapped_next = 1'b1;
         end
         `SOFTWARE_TRIGGER_IDX: begin
            rmapped_next = 1'b1;
         end
         `ACTIVE_STATUS_IDX: begin
            // applied counts, one nibble per stage
            for (int s = 0; s < STAGES; s++) begin
               rdata_next[s*4 +: 4] = count_active_reg[s];
            end
            rmapped_next = 1'b1;
         end
         default: begin
            for (int s = 0; s < STAGES; s++) begin
               if (ar_idx == 8'(`STAGE1_CANCELER_COUNT_IDX + s * `STAGE_STRIDE)) begin
                  rdata_next   = {28'h0, count_shadow_reg[s]};
                  rmapped_next = 1'b1;
               end
               if (ar_idx == 8'(`STAGE1_DETECT_THRESHOLD_SQ_IDX + s * `STAGE_STRIDE)) begin
                  rdata_next   = {16'h0, detect_reg[s]};
                  rmapped_next = 1'b1;
               end
               if (ar_idx == 8'(`STAGE1_GAIN_THRESHOLD_SQ_IDX + s * `STAGE_STRIDE)) begin
                  rdata_next   = {16'h0, gain_reg[s]};
                  rmapped_next = 1'b1;
               end
               if (ar_idx == 8'(`STAGE1_PULSE_DELAY_IDX + s * `STAGE_STRIDE)) begin
                  rdata_next   = {24'h0, delay_shadow_reg[s]}; // see RULE11
                  rmapped_next = 1'b1;
               end
            end
         end
      endcase
   end

   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `AXI_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdata_next;
         s_axi_rresp  <= rmapped_next ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ==== verif/peak_cancel_stage_config_sva.sv ====
// assertion checker for the stage configuration bank
// assumes it is bound onto the top module and sees its ports only
`timescale 1ns/1ps
module peak_cancel_stage_config_sva #(
   parameter int STAGES = 4
) (
   input wire logic                  aclk,                // core clock
   input wire logic                  aresetn,             // sync reset, low
   input wire logic                  s_axi_awvalid,       // write address valid
   input wire logic                  s_axi_awready,       // write address ready
   input wire logic                  s_axi_wvalid,        // write data valid
   input wire logic                  s_axi_wready,        // write data ready
   input wire logic                  s_axi_bvalid,        // write response valid
   input wire logic                  s_axi_bready,        // write response ready
   input wire logic                  s_axi_arvalid,       // read address valid
   input wire logic                  s_axi_arready,       // read address ready
   input wire logic [31:0]           s_axi_rdata,         // read data
   input wire logic                  s_axi_rvalid,        // read data valid
   input wire logic                  s_axi_rready,        // read data ready
   input wire logic [STAGES*4-1:0]   active_count,        // applied RAM counts
   input wire logic [STAGES*6-1:0]   active_cancelers,    // cancelers per stage
   input wire logic [STAGES*8-1:0]   active_delay,        // applied delays
   input wire logic                  resource_sync_pulse, // counts applied
   input wire logic                  cancel_sync_pulse    // delays applied
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence seq_aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence seq_ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WR_ANSWER: assert property (seq_aw_w_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   AST_WR_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   AST_B_STANDS: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
   AST_B_DROP: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   AST_RD_ANSWER: assert property (seq_ar_taken |=> s_axi_rvalid)
      else $error("read data late");
   AST_R_STANDS: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data not held");
   AST_RD_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   AST_COUNT_HOLD: assert property (!resource_sync_pulse |=> $stable(active_count))
      else $error("counts changed without sync");
   AST_DELAY_HOLD: assert property (!cancel_sync_pulse |=> $stable(active_delay))
      else $error("delays changed without sync");
   AST_CANCELERS: assert property (active_cancelers == {active_count[15:12], 2'b00,
      active_count[11:8], 2'b00, active_count[7:4], 2'b00, active_count[3:0], 2'b00})
      else $error("canceler total not four per unit");
endmodule

// ==== verif/peak_cancel_stage_config_tb.sv ====
// self-checking bench for the stage configuration bank
// assumes the defines header on the include path; drives AXI4-Lite itself
`timescale 1ns/1ps
`include "peak_cancel_stage_defines.svh"
module peak_cancel_stage_config_tb import peak_cancel_stage_pkg::*;;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        timer_sync, sync_a, sync_b, awready, wready, bvalid, arready, rvalid;
   logic        res_pulse, can_pulse;
   logic [9:0]  awaddr, araddr;
   logic [31:0] wdata, rdata, act_delay;
   logic [3:0]  wstrb, exp4, v;
   logic [1:0]  bresp, rresp;
   logic [15:0] act_count;
   logic [23:0] act_canc;
   logic [63:0] det_th, gain_th;
   int          n_errors, tests_run;
   logic [7:0]  idx_list [13] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h38, 8'h39, 8'h3A,
                                  8'h3B, 8'h40, 8'h41, 8'h42, 8'h43, 8'h48};
   peak_cancel_stage_config #(.STAGES(4)) u_dut (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .timer_sync(timer_sync), .sync_a(sync_a), .sync_b(sync_b), .active_count(act_count),
      .active_cancelers(act_canc), .active_delay(act_delay), .detect_thresh_sq(det_th),
      .gain_thresh_sq(gain_th), .resource_sync_pulse(res_pulse), .cancel_sync_pulse(can_pulse));
   initial begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      tests_run++;
      if (got !== exp) begin
         $display("unexpected %s expected %h seen %h", what, exp, got);
         n_errors++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
      bit aw_ok, w_ok;
      aw_ok = 0;
      w_ok = 0;
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("bresp", er, bresp);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [31:0] ed, input logic [1:0] er);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk("rdata", ed, rdata);
      chk("rresp", er, rresp);
   endtask
   // one-cycle event on timer, sync a or sync b
   task automatic pulse(input int src, input logic [1:0] ep);
      if (src == 0) timer_sync <= 1'b1;
      else if (src == 1) sync_a <= 1'b1;
      else sync_b <= 1'b1;
      @(posedge aclk);
      chk("sync pulses", ep, {res_pulse, can_pulse});
      timer_sync <= 1'b0;
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      tick(3);
   endtask
   initial begin
      repeat (6000) @(posedge aclk);
      n_errors++;
      final_report;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready, timer_sync, sync_a, sync_b} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      n_errors = 0;
      tests_run = 0;
      tick(4);
      aresetn <= 1'b1;
      tick(1);
      foreach (idx_list[i]) rd(idx_list[i], 32'h0, `AXI_OKAY);
      chk("count at reset", 16'h0000, act_count);
      $display("test reset values done");
      for (int s = 0; s < 4; s++) begin
         wr(8'(8'h31 + 8 * s), 32'hFFFF_A500 | s, `AXI_OKAY);
         wr(8'(8'h32 + 8 * s), 32'hFFFF_5A00 | s, `AXI_OKAY);
         rd(8'(8'h31 + 8 * s), 32'h0000_A500 | s, `AXI_OKAY);
         rd(8'(8'h32 + 8 * s), 32'h0000_5A00 | s, `AXI_OKAY);
         chk("detect out", 16'hA500 | s, det_th[16*s +: 16]);
         chk("gain out", 16'h5A00 | s, gain_th[16*s +: 16]);
      end
      $display("test thresholds done");
      // stages 1 to 3 stay zero so stage 4 alone keeps the sum legal
      exp4 = 4'h0;
      for (int sel = 0; sel < 8; sel++) begin
         wr(8'h1F, 32'(sel), `AXI_OKAY);
         for (int src = 0; src < 3; src++) begin
            v = 4'(((sel * 3 + src) % 8) + 1);
            wr(8'h48, {28'hFFFFFFF, v}, `AXI_OKAY);
            rd(8'h48, {28'h0, v}, `AXI_OKAY);
            if (sel == 5) exp4 = v;
            chk("count before sync", exp4, act_count[15:12]);
            pulse(src, {sel == src + 2 || sel == 5, 1'b0});
            if (sel == src + 2) exp4 = v;
            chk("count after sync", exp4, act_count[15:12]);
         end
      end
      chk("stage 4 cancelers", {exp4, 2'b00}, act_canc[23:18]);
      $display("test resource sync sources done");
      wr(8'h1F, 32'h1, `AXI_OKAY);
      wr(8'h48, 32'h0, `AXI_OKAY);
      wr(8'h30, 32'h2, `AXI_OKAY);
      wr(8'h38, 32'h1, `AXI_OKAY);
      wr(8'h40, 32'h5, `AXI_OKAY);
      tick(2);
      chk("count held", {exp4, 12'h000}, act_count);
      wr(8'h1D, 32'h40, `AXI_OKAY);
      tick(3);
      chk("count applied", 16'h0512, act_count);
      chk("cancelers", 24'h014108, act_canc);
      chk("delay untouched", 32'h0, act_delay);
      rd(8'h1C, 32'h0000_0512, `AXI_OKAY);
      rd(8'h1F, 32'h1, `AXI_OKAY);
      rd(8'h1D, 32'h0, `AXI_OKAY);
      $display("test software trigger done");
      wr(8'h1E, 32'h3, `AXI_OKAY);
      wr(8'h33, 32'hABCD_1205, `AXI_OKAY);
      wr(8'h3B, 32'h0000_FFFF, `AXI_OKAY);
      wr(8'h43, 32'h0000_0180, `AXI_OKAY);
      rd(8'h33, 32'h05, `AXI_OKAY);
      rd(8'h3B, 32'hFF, `AXI_OKAY);
      pulse(0, 2'b00);
      chk("delay held", 32'h0, act_delay);
      pulse(1, 2'b01);
      chk("delay applied", 32'h0080_FF05, act_delay);
      wr(8'h1E, 32'h1, `AXI_OKAY);
      wr(8'h33, 32'h06, `AXI_OKAY);
      wr(8'h30, 32'h1, `AXI_OKAY);
      wr(8'h1D, 32'h80, `AXI_OKAY);
      tick(3);
      chk("delay by trigger", 32'h0080_FF06, act_delay);
      chk("count kept", 16'h0512, act_count);
      $display("test delay sync done");
      wr(8'h35, 32'h1234, `AXI_SLVERR);
      rd(8'h35, 32'h0, `AXI_SLVERR);
      $display("test unmapped done");
      final_report;
   end
endmodule
bind peak_cancel_stage_config peak_cancel_stage_config_sva #(.STAGES(STAGES)) u_sva (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .active_count(active_count),
   .active_cancelers(active_cancelers), .active_delay(active_delay),
   .resource_sync_pulse(resource_sync_pulse), .cancel_sync_pulse(cancel_sync_pulse));
